/* design/ivl_pkg.sv */
// Purpose: Shared constants and carriers for the vectored interrupt latency unit
// Assumes: Seventeen maskable sources plus reset, two priority levels
// Notes: Vector of source n is VEC_BASE plus n times VEC_STEP
package ivl_pkg;
	localparam int NUM_SRC = 17;
	localparam int IDX_W = 5;
	localparam int VEC_W = 16;
	localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
	localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
	localparam logic [VEC_W-1:0] VEC_STEP = 16'h0008;
	localparam logic [VEC_W-1:0] VEC_LAST = 16'h0083;
	localparam int CALL_CYCLES = 5;
	localparam logic [2:0] CALL_CNT_LOAD = 3'h5;
	// Sources whose flags clear by hardware on vectoring: timers always, external ones only when their ext_edge_mode bit is set
	localparam logic [IDX_W-1:0] SRC_EXT0 = 5'h00;
	localparam logic [IDX_W-1:0] SRC_TMR0 = 5'h01;
	localparam logic [IDX_W-1:0] SRC_EXT1 = 5'h02;
	localparam logic [IDX_W-1:0] SRC_TMR1 = 5'h03;
	localparam logic [1:0] SVC_NONE = 2'h0;

	typedef struct packed {
		logic instr_done;
		logic return_from_handler_done;
		logic stall;
	} ivl_cpu_t;

	typedef struct packed {
		logic active;
		logic high_level;
		logic [VEC_W-1:0] vector;
	} ivl_call_t;

	typedef enum logic [0:0] {
		IVL_IDLE = 1'b0,
		IVL_CALL = 1'b1
	} ivl_state_t;
endpackage

/* design/ivl_vectored_interrupt_latency_unit.sv */
// Purpose: Samples pending flags, ranks them and forces a long call to the winning vector
// Assumes: Flags, enables and CPU strobes come from logic on clk
// Notes: Worst case latency is set by CPU instruction lengths, not by this unit
`timescale 1ns/1ns

module ivl_vectored_interrupt_latency_unit
	import ivl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [NUM_SRC-1:0] pending_flags,
	input wire logic global_interrupt_enable,
	input wire logic [NUM_SRC-1:0] source_enable,
	input wire logic [NUM_SRC-1:0] source_high_priority,
	input wire logic [1:0] ext_edge_mode,
	input wire ivl_cpu_t cpu,
	output ivl_call_t long_call_to_handler,
	output logic [IDX_W-1:0] call_source,
	output logic [NUM_SRC-1:0] flag_clear,
	output logic [1:0] in_service
);
	initial
	begin
		if (NUM_SRC != 17 || VEC_BASE + VEC_STEP * 16'(NUM_SRC - 1) != VEC_LAST)
			$error("Source count does not fit the vector table");
	end

	ivl_state_t state_reg, state_next;
	ivl_call_t call_reg, call_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [IDX_W-1:0] src_reg, src_next;
	logic [NUM_SRC-1:0] req_reg, req_next;
	logic [NUM_SRC-1:0] clr_reg, clr_next;
	logic [1:0] svc_reg, svc_next;
	logic after_ret_reg, after_ret_next;
	logic hi_any, lo_any, win_hi, win_ok, boundary;
	logic [IDX_W-1:0] hi_idx, lo_idx, win_idx;
	logic [NUM_SRC-1:0] auto_clr;

	always_comb
	begin
		auto_clr = '0;
		auto_clr[SRC_EXT0] = ext_edge_mode[0];
		auto_clr[SRC_TMR0] = 1'b1;
		auto_clr[SRC_EXT1] = ext_edge_mode[1];
		auto_clr[SRC_TMR1] = 1'b1;
	end

	// scan from top so the lowest index is the last to win
	always_comb
	begin
		hi_any = 1'b0;
		lo_any = 1'b0;
		hi_idx = '0;
		lo_idx = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (req_reg[i] && source_high_priority[i])
			begin
				hi_any = 1'b1;
				hi_idx = IDX_W'(i);
			end
			if (req_reg[i] && !source_high_priority[i])
			begin
				lo_any = 1'b1;
				lo_idx = IDX_W'(i);
			end
		end
	end

	// high may enter unless a high handler runs; low needs no handler in service
	// equal or higher level in service holds the request pending
	always_comb
	begin
		win_hi = 1'b0;
		win_idx = '0;
		win_ok = 1'b0;
		if (hi_any && !svc_reg[1])
		begin
			win_hi = 1'b1;
			win_idx = hi_idx;
			win_ok = 1'b1;
		end
		else if (lo_any && svc_reg == SVC_NONE)
		begin
			win_idx = lo_idx;
			win_ok = 1'b1;
		end
	end

	// the return itself never starts a call; the single instruction after it may
	// stalled cycles are no instruction boundary
	assign boundary = cpu.instr_done && !cpu.return_from_handler_done && !cpu.stall;

	always_comb
	begin
		// per source enable behind the global enable
		req_next = pending_flags & source_enable & {NUM_SRC{global_interrupt_enable}};
		after_ret_next = after_ret_reg;
		if (cpu.return_from_handler_done)
			after_ret_next = 1'b1;
		else if (cpu.instr_done && !cpu.stall)
			after_ret_next = 1'b0;
	end

	always_comb
	begin
		state_next = state_reg;
		call_next = call_reg;
		cnt_next = cnt_reg;
		src_next = src_reg;
		clr_next = '0;
		svc_next = svc_reg;
		// return releases the highest level in service
		if (cpu.return_from_handler_done)
		begin
			if (svc_reg[1])
				svc_next[1] = 1'b0;
			else
				svc_next[0] = 1'b0;
		end
		case (state_reg)
			IVL_IDLE:
			begin
				// detect clock done, start the five call clocks
				if (boundary && win_ok)
				begin
					state_next = IVL_CALL;
					cnt_next = CALL_CNT_LOAD;
					src_next = win_idx;
					call_next.active = 1'b1;
					call_next.high_level = win_hi;
					call_next.vector = VEC_BASE + VEC_STEP * VEC_W'(win_idx);
					svc_next[win_hi] = 1'b1;
					// pulse clears with the call start
					clr_next[win_idx] = auto_clr[win_idx];
				end
			end
			IVL_CALL:
			begin
				// stall freezes the call; total follows from CPU timing
				if (!cpu.stall)
				begin
					cnt_next = cnt_reg - 3'h1;
					if (cnt_reg == 3'h1)
					begin
						state_next = IVL_IDLE;
						call_next.active = 1'b0;
					end
				end
			end
			default:
			begin
				state_next = IVL_IDLE;
				call_next.active = 1'b0;
			end
		endcase
	end

	// reset leaves the reset vector on the call port, ahead of any source
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= IVL_IDLE;
			call_reg <= '{active: 1'b0, high_level: 1'b1, vector: RESET_VECTOR};
			cnt_reg <= '0;
			src_reg <= '0;
			req_reg <= '0;
			clr_reg <= '0;
			svc_reg <= SVC_NONE;
			after_ret_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			call_reg <= call_next;
			cnt_reg <= cnt_next;
			src_reg <= src_next;
			req_reg <= req_next;
			clr_reg <= clr_next;
			svc_reg <= svc_next;
			after_ret_reg <= after_ret_next;
		end
	end

	assign long_call_to_handler = call_reg;
	assign call_source = src_reg;
	assign flag_clear = clr_reg;
	assign in_service = svc_reg;

	// the call lasts at least five clocks
	call_min_len_a: assert property (@(posedge clk) disable iff (rst)
		$rose(call_reg.active) |-> call_reg.active[*5])
		else $error("Forced call shorter than five clocks");

	// without a stall it ends after exactly five
	call_exact_len_a: assert property (@(posedge clk) disable iff (rst)
		($rose(call_reg.active) && !cpu.stall ##1 !cpu.stall[*4]) |=> !call_reg.active)
		else $error("Unstalled call not five clocks");

	vector_value_a: assert property (@(posedge clk) disable iff (rst)
		$rose(call_reg.active) |-> call_reg.vector == VEC_BASE + VEC_STEP * VEC_W'(src_reg))
		else $error("Call vector does not match source");

	// no call on the return instruction itself
	ret_gap_a: assert property (@(posedge clk) disable iff (rst)
		cpu.return_from_handler_done |=> !$rose(call_reg.active))
		else $error("Call issued without an instruction after return");

	// the instruction after a return carries a pending call
	ret_next_call_a: assert property (@(posedge clk) disable iff (rst)
		(after_ret_reg && cpu.instr_done && !cpu.return_from_handler_done && !cpu.stall && win_ok
			&& state_reg == IVL_IDLE) |=> $rose(call_reg.active))
		else $error("Pending call not taken one instruction after return");

	global_off_a: assert property (@(posedge clk) disable iff (rst)
		!global_interrupt_enable |=> req_reg == '0)
		else $error("Request sampled while globally disabled");

	stall_wait_a: assert property (@(posedge clk) disable iff (rst)
		(cpu.stall && !call_reg.active) |=> !$rose(call_reg.active))
		else $error("Call started during a stall");

	// a high handler is never preempted
	high_hold_a: assert property (@(posedge clk) disable iff (rst)
		(svc_reg[1] && !cpu.return_from_handler_done) |=> !$rose(call_reg.active))
		else $error("High handler preempted");

	// with any handler running only a high request may enter
	low_blocked_a: assert property (@(posedge clk) disable iff (rst)
		($rose(call_reg.active) && $past(svc_reg) != SVC_NONE) |-> call_reg.high_level)
		else $error("Low request entered over a running handler");

	// timer 0 flag cleared with its call
	auto_clear_a: assert property (@(posedge clk) disable iff (rst)
		($rose(call_reg.active) && src_reg == SRC_TMR0) |-> flag_clear[SRC_TMR0])
		else $error("Timer 0 flag not cleared on vectoring");

	svc_record_a: assert property (@(posedge clk) disable iff (rst)
		$rose(call_reg.active) |-> svc_reg[call_reg.high_level])
		else $error("Service level not recorded");
endmodule

/* dv/ivl_cpu_model.sv */
// Purpose: Variable-length instruction sequencer facing the unit
// Assumes: Instruction length in clocks comes from the bench, one by default
// Notes: Quiet while the forced call runs or while stalled
`timescale 1ns/1ns
module ivl_cpu_model
	import ivl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic busy,
	input wire logic return_from_handler_req,
	input wire logic stall_req,
	input wire logic [3:0] instr_len,
	output ivl_cpu_t cpu
);
	logic [3:0] phase_reg;

	// A stall holds the phase, a forced call restarts it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			phase_reg <= 4'h0;
		else if (busy)
			phase_reg <= 4'h0;
		else if (!stall_req)
			phase_reg <= cpu.instr_done ? 4'h0 : phase_reg + 4'h1;
	end

	always_comb
	begin
		cpu.stall = stall_req;
		cpu.instr_done = !busy && !stall_req && !rst && (phase_reg + 4'h1 >= instr_len);
		cpu.return_from_handler_done = cpu.instr_done && return_from_handler_req;
	end
endmodule

/* dv/testbench.sv */
// Purpose: Random and directed checks of the interrupt unit
// Assumes: One-cycle instructions from the sequencer model, except six and eight clocks in the longest wait check
// Notes: Inputs change on the falling edge only
`timescale 1ns/1ns
module testbench;
	import ivl_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic [NUM_SRC-1:0] fl = 0;
	logic [NUM_SRC-1:0] en = 0;
	logic [NUM_SRC-1:0] hp = 0;
	logic ge = 0;
	logic [1:0] em = 0;
	logic return_from_handler_req = 0;
	logic stall_req = 0;
	logic [3:0] ilen = 4'h1;
	ivl_cpu_t cpu;
	ivl_call_t call;
	logic [IDX_W-1:0] src;
	logic [NUM_SRC-1:0] clr;
	logic [1:0] ins;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	int seed = 32'hC6ED;
	int gap;
	ivl_vectored_interrupt_latency_unit i_dut (.clk(clk), .rst(rst), .pending_flags(fl),
		.global_interrupt_enable(ge), .source_enable(en), .source_high_priority(hp),
		.ext_edge_mode(em), .cpu(cpu), .long_call_to_handler(call), .call_source(src),
		.flag_clear(clr), .in_service(ins));
	ivl_cpu_model i_cpu (.clk(clk), .rst(rst), .busy(call.active), .return_from_handler_req(return_from_handler_req),
		.stall_req(stall_req), .instr_len(ilen), .cpu(cpu));
	initial forever #4 clk = ~clk;
	task print_verdict;
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard, far above the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			print_verdict;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Reset shows the reset vector and no call
	task reset_check;
		rst = 1;
		@(negedge clk);
		chk(call.active, 0);
		chk(call.vector, RESET_VECTOR);
		chk(call.high_level, 1);
		chk(src, 0);
		chk(clr, 0);
		chk(ins, 0);
		rst = 0;
	endtask
	task service(input int pre_stall, input int stall_len, input bit do_ret);
		int best;
		int lat;
		int dur;
		logic [1:0] ins0;
		logic [NUM_SRC-1:0] eclr;
		best = -1;
		ins0 = ins;
		// Level first, then lowest index; busy levels block
		for (int i = 0; i < NUM_SRC; i++)
			if (ge && en[i] && fl[i] && (hp[i] ? !ins0[1] : ins0 == 2'h0))
				if (best < 0 || (hp[i] && !hp[best]))
					best = i;
		lat = 0;
		while (call.active !== 1'b1 && lat < 12)
		begin
			@(negedge clk);
			lat++;
			if (lat == 1)
				stall_req = (pre_stall > 0);
			else if (lat == pre_stall + 1)
				stall_req = 0;
		end
		if (best < 0)
			chk(call.active, 0);
		else
		begin
			eclr = 0;
			eclr[best] = (best == 1 || best == 3 || (best == 0 && em[0]) || (best == 2 && em[1]));
			chk(lat, 2 + pre_stall);
			chk(call.vector, VEC_BASE + VEC_STEP * best);
			chk(src, best);
			chk(call.high_level, hp[best]);
			chk(clr, eclr);
			chk(ins, ins0 | (hp[best] ? 2'h2 : 2'h1));
			fl = 0;
			stall_req = (stall_len > 0);
			dur = 1;
			while (call.active === 1'b1 && dur < 30)
			begin
				@(negedge clk);
				dur++;
				if (dur > stall_len)
					stall_req = 0;
			end
			chk(dur, 6 + stall_len);
		end
		if (do_ret)
		begin
			ins0 = ins;
			return_from_handler_req = 1;
			@(negedge clk);
			return_from_handler_req = 0;
			chk(ins, ins0[1] ? {1'b0, ins0[0]} : 2'h0);
		end
	endtask
	initial
	begin
		repeat (4) @(negedge clk);
		reset_check;
		for (int k = 0; k < 24; k++)
		begin
			fl = 17'($random(seed));
			en = 17'($random(seed));
			hp = 17'($random(seed));
			ge = 1'($random(seed));
			em = 2'($random(seed));
			service(k % 4, k % 3, 1);
		end
		// Reset again in mid-run
		reset_check;
		en = '1;
		ge = 1;
		hp = 17'h00020;
		fl = 17'h00010;
		service(0, 0, 0);
		// Second low request must wait behind the running low handler
		fl = 17'h00010;
		service(0, 0, 0);
		// A held low request enters one instruction after the return
		fl = 17'h00040;
		return_from_handler_req = 1;
		gap = 0;
		while (call.active !== 1'b1 && gap < 12)
		begin
			@(negedge clk);
			gap++;
			if (gap == 1)
				return_from_handler_req = 0;
		end
		chk(gap, 2);
		chk(src, 5'h06);
		chk(ins, 2'h1);
		while (call.active === 1'b1 && gap < 30)
		begin
			@(negedge clk);
			gap++;
		end
		fl = 17'h00020;
		service(0, 0, 1);
		service(0, 0, 1);
		// Longest wait: return then divide; detect overlaps the return's first clock
		@(negedge clk);
		fl = 17'h00001;
		ilen = 4'h6;
		return_from_handler_req = 1;
		gap = 0;
		while (call.active !== 1'b1 && gap < 30)
		begin
			@(negedge clk);
			gap++;
			if (gap == 6)
			begin
				return_from_handler_req = 0;
				ilen = 4'h8;
			end
		end
		chk(gap, 6 + 8);
		while (call.active === 1'b1 && gap < 40)
		begin
			@(negedge clk);
			gap++;
		end
		chk(gap, 6 + 8 + CALL_CYCLES);
		print_verdict;
	end
endmodule
